// >>> logic/pressure_irq_stretch_window.sv
// Window comparator, pulse stretch timer and interrupt pin stage.
//
// Design decision made here: the strobed register port.
`default_nettype none

module pressure_irq_stretch_window #(
  parameter int unsigned TICK_PERIOD = pressure_irq_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  // Sample from the pressure data path.
  input  wire pressure_irq_pkg::sample_t  i_sample,
  // Register port.
  input  wire pressure_irq_pkg::reg_req_t i_req,
  output logic [7:0]                      o_rdata,
  // Interrupt pin, open drain.
  output logic                            o_int_pin_out,
  output logic                            o_int_pin_oe,
  output logic                            o_int_pull_up_en,
  output logic                            o_int_pull_dn_en,
  // Level interrupt to the local controller.
  output logic                            o_irq
);
  import pressure_irq_pkg::*;

  stretch_sel_t          stretch_sel_r, stretch_sel_nxt;
  logic                  window_in_r, window_in_nxt;
  logic                  drive_low_r, drive_low_nxt;
  logic                  init_done_lock_r, init_done_lock_nxt;
  logic [15:0]           thr_hi_r, thr_hi_nxt;
  logic [15:0]           thr_lo_r, thr_lo_nxt;
  logic [EV_W-1:0]       ev_stat_r, ev_stat_nxt;
  logic [EV_W-1:0]       ev_mask_r, ev_mask_nxt;
  logic [7:0]            rdata_nxt;
  logic                  cond_r, cond_nxt;
  logic [TIMER_W-1:0]    timer_r, timer_nxt;
  logic [TIMER_W-1:0]    load_val;
  logic                  tick;
  logic                  above, below, outside, both_off, cond_now, load, expire;
  logic                  pin_active;
  logic [EV_W-1:0]       ev_set;

  // Tick source for the stretch timer.
  stretch_tick_gen #(
    .PERIOD (TICK_PERIOD)
  ) u_tick (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .o_tick  (tick)
  );

  // Window comparison of the incoming sample; a zero threshold drops its side.
  always_comb begin
    both_off = (thr_hi_r == THR_OFF) && (thr_lo_r == THR_OFF);               // see RULE9
    above    = (thr_hi_r != THR_OFF) && (i_sample.value > thr_hi_r);         // see RULE8
    below    = (thr_lo_r != THR_OFF) && (i_sample.value < thr_lo_r);         // see RULE8
    outside  = above || below;
    cond_now = !both_off && (window_in_r ? !outside : outside);              // see RULE7
  end

  // Hold time chosen by the stretch selection.
  always_comb begin
    unique case (stretch_sel_r)                                              // see RULE1
      STRETCH_NONE:  load_val = TIMER_ZERO;
      STRETCH_16MS:  load_val = LOAD_16;                                     // see RULE2
      STRETCH_64MS:  load_val = LOAD_64;
      STRETCH_256MS: load_val = LOAD_256;
    endcase
  end

  // Condition latch and stretch timer next state.
  always_comb begin
    load     = i_sample.valid && cond_now;                                   // see RULE6
    expire   = tick && (timer_r == TIMER_ONE) && !load;
    cond_nxt = i_sample.valid ? cond_now : cond_r;                           // see RULE3
    if (load) begin
      timer_nxt = load_val;                                                  // see RULE6
    end else if (tick && (timer_r != TIMER_ZERO)) begin
      timer_nxt = timer_r - TIMER_ONE;                                       // see RULE5
    end else begin
      timer_nxt = timer_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cond_r  <= 1'b0;
      timer_r <= TIMER_ZERO;                                                 // see RULE12
    end else begin
      cond_r  <= cond_nxt;
      timer_r <= timer_nxt;
    end
  end

  // Pin level: direct follow without stretch, timer only with stretch.
  always_comb begin
    if (both_off) begin
      pin_active = 1'b0;                                                     // see RULE9
    end else if (stretch_sel_r == STRETCH_NONE) begin
      pin_active = cond_r;                                                   // see RULE3
    end else begin
      pin_active = (timer_r != TIMER_ZERO);                                  // see RULE4
    end
  end

  // The pin is driven only while active, towards the active level; when idle it is
  // released and the selected pull current brings it back, so an idle pin never
  // fights a second open-drain source wired onto the same host line.
  assign o_int_pin_out    = !drive_low_r;                                    // see RULE11
  assign o_int_pin_oe     = pin_active;                                      // see RULE11
  assign o_int_pull_up_en = drive_low_r;                                     // see RULE11
  assign o_int_pull_dn_en = !drive_low_r;

  // Register writes; the lock is one-way until reset and freezes setup and thresholds.
  always_comb begin
    stretch_sel_nxt    = stretch_sel_r;
    window_in_nxt      = window_in_r;
    drive_low_nxt      = drive_low_r;
    init_done_lock_nxt = init_done_lock_r;
    thr_hi_nxt         = thr_hi_r;
    thr_lo_nxt         = thr_lo_r;
    ev_mask_nxt        = ev_mask_r;
    ev_set             = '0;
    ev_set[EV_COND]    = load;
    ev_set[EV_EXPIRE]  = expire;
    ev_stat_nxt        = ev_stat_r;
    if (i_req.wr) begin
      unique case (i_req.addr)
        ADDR_SETUP: begin
          if (!init_done_lock_r) begin                                       // see RULE10
            stretch_sel_nxt = stretch_sel_t'(i_req.wdata[SEL_MSB:SEL_LSB]);  // see RULE1
            window_in_nxt   = i_req.wdata[POL_BIT];                          // see RULE7
          end
        end
        ADDR_HI_L: if (!init_done_lock_r) thr_hi_nxt[7:0]  = i_req.wdata;
        ADDR_HI_H: if (!init_done_lock_r) thr_hi_nxt[15:8] = i_req.wdata;
        ADDR_LO_L: if (!init_done_lock_r) thr_lo_nxt[7:0]  = i_req.wdata;
        ADDR_LO_H: if (!init_done_lock_r) thr_lo_nxt[15:8] = i_req.wdata;
        ADDR_PIN_CFG:  drive_low_nxt = i_req.wdata[DRIVE_BIT];
        ADDR_LOCK:     init_done_lock_nxt = init_done_lock_r | i_req.wdata[LOCK_BIT];
        ADDR_IRQ_STAT: ev_stat_nxt = ev_stat_r & ~i_req.wdata[EV_W-1:0];
        ADDR_IRQ_MASK: ev_mask_nxt = i_req.wdata[EV_W-1:0];
        default: ;
      endcase
    end
    // A new event beats a clear written in the same cycle.
    ev_stat_nxt = ev_stat_nxt | ev_set;
  end

  // Read mux; unmapped addresses and reserved bits read zero.
  always_comb begin
    rdata_nxt = BYTE_RST;
    if (i_req.rd) begin
      unique case (i_req.addr)
        ADDR_SETUP: begin
          rdata_nxt[SEL_MSB:SEL_LSB] = stretch_sel_r;
          rdata_nxt[POL_BIT]         = window_in_r;
        end
        ADDR_HI_L:     rdata_nxt = thr_hi_r[7:0];
        ADDR_HI_H:     rdata_nxt = thr_hi_r[15:8];
        ADDR_LO_L:     rdata_nxt = thr_lo_r[7:0];
        ADDR_LO_H:     rdata_nxt = thr_lo_r[15:8];
        ADDR_PIN_CFG:  rdata_nxt[DRIVE_BIT] = drive_low_r;
        ADDR_LOCK:     rdata_nxt[LOCK_BIT] = init_done_lock_r;
        ADDR_IRQ_STAT: rdata_nxt[EV_W-1:0] = ev_stat_r;
        ADDR_IRQ_MASK: rdata_nxt[EV_W-1:0] = ev_mask_r;
        ADDR_STATE:    rdata_nxt = {5'h00, pin_active, cond_r, timer_r != TIMER_ZERO};
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      stretch_sel_r    <= STRETCH_NONE;
      window_in_r      <= 1'b0;
      drive_low_r      <= 1'b0;
      init_done_lock_r <= 1'b0;
      thr_hi_r         <= THR_RST;
      thr_lo_r         <= THR_RST;
      ev_stat_r        <= EV_RST;
      ev_mask_r        <= EV_RST;
      o_rdata          <= BYTE_RST;
    end else begin
      stretch_sel_r    <= stretch_sel_nxt;
      window_in_r      <= window_in_nxt;
      drive_low_r      <= drive_low_nxt;
      init_done_lock_r <= init_done_lock_nxt;
      thr_hi_r         <= thr_hi_nxt;
      thr_lo_r         <= thr_lo_nxt;
      ev_stat_r        <= ev_stat_nxt;
      ev_mask_r        <= ev_mask_nxt;
      o_rdata          <= rdata_nxt;
    end
  end

  // Interrupt level is a pure function of registers, so it never glitches.
  assign o_irq = |(ev_stat_r & ev_mask_r);

  // Checks on the block's own behaviour.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  AST_SEL_WRITE: assert property ( // see RULE1
    (i_req.wr && i_req.addr == ADDR_SETUP && !init_done_lock_r) |=>
      (stretch_sel_r == stretch_sel_t'($past(i_req.wdata[SEL_MSB:SEL_LSB]))))
    else $error("Stretch selection not taken from setup write.");

  AST_LOAD_16: assert property ( // see RULE2
    (i_sample.valid && cond_now && stretch_sel_r == STRETCH_16MS) |=> (timer_r == LOAD_16))
    else $error("Timer not loaded with the 16 ms hold.");

  AST_DIRECT_FOLLOW: assert property ( // see RULE3
    (stretch_sel_r == STRETCH_NONE && !both_off) |-> (o_int_pin_oe == cond_r))
    else $error("Pin does not follow the latest condition.");

  AST_TIMER_DRIVES: assert property ( // see RULE4
    (stretch_sel_r != STRETCH_NONE && !both_off) |-> (o_int_pin_oe == (timer_r != TIMER_ZERO)))
    else $error("Pin does not follow the stretch timer.");

  AST_NO_WRAP: assert property ( // see RULE5
    (timer_r == TIMER_ZERO && !load) |=> (timer_r == TIMER_ZERO))
    else $error("Timer left zero without a reload.");

  AST_TICK_DEC: assert property ( // see RULE5
    (tick && timer_r != TIMER_ZERO && !load) |=> (timer_r == $past(timer_r) - TIMER_ONE))
    else $error("Timer did not step down on a tick.");

  AST_RELOAD_ONLY: assert property ( // see RULE6
    (timer_r > $past(timer_r)) |-> $past(load))
    else $error("Timer rose without a qualifying sample.");

  AST_INSIDE: assert property ( // see RULE7
    (i_sample.valid && window_in_r && thr_hi_r != THR_OFF && thr_lo_r != THR_OFF &&
     i_sample.value <= thr_hi_r && i_sample.value >= thr_lo_r) |=> cond_r)
    else $error("Inside-window sample did not raise the condition.");

  AST_ONE_SIDE: assert property ( // see RULE8
    (i_sample.valid && !window_in_r && thr_hi_r == THR_OFF && thr_lo_r != THR_OFF &&
     i_sample.value < thr_lo_r) |=> cond_r)
    else $error("Low side failed with the high side disabled.");

  AST_BOTH_OFF: assert property ( // see RULE9
    both_off |-> !o_int_pin_oe)
    else $error("Pin active with both thresholds zero.");

  AST_LOCKED: assert property ( // see RULE10
    (init_done_lock_r && i_req.wr && i_req.addr == ADDR_SETUP) |=>
      ($stable(stretch_sel_r) && $stable(window_in_r)))
    else $error("Setup changed while locked.");

  AST_ACTIVE_LOW: assert property ( // see RULE11
    (drive_low_r && pin_active) |-> (o_int_pin_oe && !o_int_pin_out))
    else $error("Active-low pin not pulled low when active.");

  AST_RESET_ZERO: assert property ( // see RULE12
    $past(!i_rst_b) |-> (timer_r == TIMER_ZERO && !cond_r))
    else $error("Timer or condition not clear after reset.");

  // Checks that tie the sample, timer and status paths to the pin and the registers.
  // A register write in the sample cycle is excluded where it could move the target.
  AST_SAMPLE_FOLLOW: assert property ( // see RULE3
    (i_sample.valid && stretch_sel_r == STRETCH_NONE && !both_off && !i_req.wr) |=>
      (o_int_pin_oe == $past(cond_now)))
    else $error("Pin did not follow the newest sample.");

  AST_RELOAD: assert property ( // see RULE6
    (i_sample.valid && cond_now) |=> (timer_r == $past(load_val)))
    else $error("Qualifying sample did not reload the timer.");

  AST_COND_EVENT: assert property ( // see RULE6
    load |=> ev_stat_r[EV_COND])
    else $error("Qualifying sample did not set its status bit.");

  AST_EXPIRE_SET: assert property ( // see RULE5
    (tick && timer_r == TIMER_ONE && !load) |=> (timer_r == TIMER_ZERO && ev_stat_r[EV_EXPIRE]))
    else $error("Timer end did not reach zero and set its status bit.");

  AST_BOTH_OFF_COND: assert property ( // see RULE9
    (both_off && i_sample.valid) |=> !cond_r)
    else $error("Condition raised with both thresholds zero.");

  AST_LOCK_STICKY: assert property ( // see RULE10
    init_done_lock_r |=> init_done_lock_r)
    else $error("Init lock cleared without reset.");

  AST_THR_LOCKED: assert property ( // see RULE10
    (init_done_lock_r && i_req.wr) |=> ($stable(thr_hi_r) && $stable(thr_lo_r)))
    else $error("Threshold changed while locked.");

  AST_ACTIVE_HIGH: assert property ( // see RULE11
    !drive_low_r |->
      (o_int_pin_oe == pin_active && o_int_pin_out && o_int_pull_dn_en && !o_int_pull_up_en))
    else $error("Active-high pin not driven high or not pulled down.");

  // Main scenarios that the bench is expected to reach.
  COV_STRETCH_HOLD: cover property (load && stretch_sel_r == STRETCH_16MS ##1 pin_active[*8]);
  COV_ACTIVE_LOW:   cover property (drive_low_r && pin_active);
  COV_EXPIRE:       cover property (expire);
  COV_INSIDE_HIT:   cover property (i_sample.valid && window_in_r && cond_now);
  COV_IRQ:          cover property ($rose(o_irq));

endmodule : pressure_irq_stretch_window

`default_nettype wire

// >>> common/pressure_irq_pkg.sv
// Constants, field layouts and carriers for the pressure interrupt output stage.
// Functional notes
// RULE1: Setup bits 5..4 pick hold time: none, 16 ms, 64 ms, 256 ms.
// RULE2: Hold times come from the internal tick, overshooting by at most half a millisecond.
// RULE3: With no stretch the pin follows the condition of the latest sample exactly.
// RULE4: With stretch selected the pin is active exactly while the timer is nonzero.
// RULE5: The stretch timer counts down on every tick and stops at zero.
// RULE6: Only a sample meeting the condition reloads the timer with the hold time.
// RULE7: Setup bit 3 low fires outside the window, high fires inside it.
// RULE8: A zero threshold disables that side only; the other side still compares.
// RULE9: Both thresholds zero keeps the interrupt pin inactive.
// RULE10: Setup is written during init and frozen once the init lock bit is set.
// RULE11: Drive bit low gives active-high open drain, high gives active-low.
// RULE12: Timer starts at zero after reset, so the pin starts inactive.
`default_nettype none

package pressure_irq_pkg;

  // Clock and the oscillator tick that times the stretch.
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned TICK_PERIOD_NS = 500_000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W     = 16;

  // Nominal hold times in microseconds.
  localparam int unsigned STRETCH_US_16  = 16_000;
  localparam int unsigned STRETCH_US_64  = 64_000;
  localparam int unsigned STRETCH_US_256 = 256_000;

  // Timer loads in ticks; the extra tick absorbs the free running tick phase.
  localparam int unsigned TIMER_W = 10;
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 10'h000;
  localparam logic [TIMER_W-1:0] TIMER_ONE  = 10'h001;
  localparam logic [TIMER_W-1:0] LOAD_16  = TIMER_W'(STRETCH_US_16 * 1000 / TICK_PERIOD_NS + 1);
  localparam logic [TIMER_W-1:0] LOAD_64  = TIMER_W'(STRETCH_US_64 * 1000 / TICK_PERIOD_NS + 1);
  localparam logic [TIMER_W-1:0] LOAD_256 = TIMER_W'(STRETCH_US_256 * 1000 / TICK_PERIOD_NS + 1);

  // Register byte addresses.
  localparam logic [7:0] ADDR_LOCK      = 8'h10;
  localparam logic [7:0] ADDR_PIN_CFG   = 8'h43;
  localparam logic [7:0] ADDR_SETUP     = 8'h45;
  localparam logic [7:0] ADDR_HI_L      = 8'h46;
  localparam logic [7:0] ADDR_HI_H      = 8'h47;
  localparam logic [7:0] ADDR_LO_L      = 8'h48;
  localparam logic [7:0] ADDR_LO_H      = 8'h49;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h50;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h51;
  localparam logic [7:0] ADDR_STATE     = 8'h52;

  // Field positions.
  localparam int unsigned SEL_LSB   = 4;
  localparam int unsigned SEL_MSB   = 5;
  localparam int unsigned POL_BIT   = 3;
  localparam int unsigned DRIVE_BIT = 2;
  localparam int unsigned LOCK_BIT  = 0;
  localparam int unsigned EV_COND   = 0;
  localparam int unsigned EV_EXPIRE = 1;
  localparam int unsigned EV_W      = 2;

  // Reset values and the zero threshold that turns a side off.
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [15:0] THR_RST   = 16'h0000;
  localparam logic [15:0] THR_OFF   = 16'h0000;
  localparam logic [EV_W-1:0] EV_RST = 2'h0;

  typedef enum logic [1:0] {
    STRETCH_NONE,
    STRETCH_16MS,
    STRETCH_64MS,
    STRETCH_256MS
  } stretch_sel_t;

  // One evaluated pressure sample.
  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } sample_t;

  // One register bus request.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : pressure_irq_pkg

`default_nettype wire

// >>> logic/stretch_tick_gen.sv
// Free running divider that makes the stretch timer's oscillator tick.
`default_nettype none

module stretch_tick_gen #(
  parameter int unsigned PERIOD = pressure_irq_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Tick out.
  output logic      o_tick
);
  import pressure_irq_pkg::*;

  localparam logic [TICK_CNT_W-1:0] LAST = TICK_CNT_W'(PERIOD - 1);

  logic [TICK_CNT_W-1:0] cnt_r;
  logic [TICK_CNT_W-1:0] cnt_nxt;

  // The divider never stops, so a reload lands at a random tick phase.
  always_comb begin
    cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_tick = (cnt_r == LAST);

endmodule : stretch_tick_gen

`default_nettype wire

// >>> verif/irq_host_model.sv
// Host side of the open-drain interrupt pin: resolves the wire level it sees.
`default_nettype none

module irq_host_model (
  // Clock for the floating-wire pattern.
  input  wire logic i_clk,
  // Pin drive and pull controls from the device.
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe,
  input  wire logic i_pull_up_en,
  input  wire logic i_pull_dn_en,
  // Level seen by the host input.
  output logic      o_level
);
  timeunit 1ns;
  timeprecision 1ps;

  logic float_r = 1'b0;

  // An undriven, unpulled wire must not look like a clean level, so it toggles.
  always @(posedge i_clk) begin
    float_r <= ~float_r;
  end

  // The device drive wins, then the selected pull current.
  always_comb begin
    if (i_pin_oe) begin
      o_level = i_pin_out;
    end else if (i_pull_up_en) begin
      o_level = 1'b1;
    end else if (i_pull_dn_en) begin
      o_level = 1'b0;
    end else begin
      o_level = float_r;
    end
  end

endmodule : irq_host_model

`default_nettype wire

// >>> verif/pressure_irq_stretch_window_tb.sv
// Self-checking bench for the pressure interrupt output stage.
`default_nettype none

module pressure_irq_stretch_window_tb;
  import pressure_irq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned TP = 4;

  logic       i_clk = 1'b0;
  logic       i_rst_b;
  sample_t    smp_r;
  reg_req_t   req_r;
  logic [7:0] o_rdata;
  logic       pin_out;
  logic       pin_oe;
  logic       pull_up;
  logic       pull_dn;
  logic       o_irq;
  logic       pin_level;
  logic       rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  int         fails;
  int         comparisons;
  int         seed;
  int         n;
  int         cyc;
  logic [15:0] rv;

  pressure_irq_stretch_window #(.TICK_PERIOD(TP)) uut (
    .i_clk            (i_clk),
    .i_rst_b          (i_rst_b),
    .i_sample         (smp_r),
    .i_req            (req_r),
    .o_rdata          (o_rdata),
    .o_int_pin_out    (pin_out),
    .o_int_pin_oe     (pin_oe),
    .o_int_pull_up_en (pull_up),
    .o_int_pull_dn_en (pull_dn),
    .o_irq            (o_irq)
  );

  irq_host_model host (
    .i_clk        (i_clk),
    .i_pin_out    (pin_out),
    .i_pin_oe     (pin_oe),
    .i_pull_up_en (pull_up),
    .i_pull_dn_en (pull_dn),
    .o_level      (pin_level)
  );

  // Clock at 50 ns.
  always #25 i_clk = ~i_clk;

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    req_r <= {1'b1, 1'b0, a, d};
    @(posedge i_clk);
    req_r <= '0;
    #1;
  endtask : wr

  // The expected byte is queued here and judged by the read monitor.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    req_r <= {1'b0, 1'b1, a, 8'h00};
    exp_q.push_back(e);
    @(posedge i_clk);
    req_r <= '0;
    #1;
  endtask : rd

  task automatic smp(input logic [15:0] v);
    @(posedge i_clk);
    smp_r <= {1'b1, v};
    @(posedge i_clk);
    smp_r <= {1'b0, v};
    #1;
  endtask : smp

  // Read data stand only in the cycle after the strobe, so they are taken there.
  always @(posedge i_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        chk(16'h0001, 16'h0000);
      end else begin
        chk({8'h00, o_rdata}, {8'h00, exp_q.pop_front()});
      end
    end
    rd_seen <= req_r.rd;
  end

  // Sample table for the unstretched mode: setup byte, value, expected state.
  logic [7:0]  tb_set[5] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h08};
  logic [15:0] tb_val[5] = '{16'h2000, 16'h0001, 16'h0001, 16'h1000, 16'h2000};
  logic [7:0]  tb_st[5]  = '{8'h06, 8'h00, 8'h06, 8'h06, 8'h00};
  logic [7:0]  rst_a[9]  = '{ADDR_SETUP, ADDR_HI_L, ADDR_HI_H, ADDR_LO_L, ADDR_LO_H,
                             ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_STATE, 8'h7F};

  initial begin
    i_rst_b = 1'b0;
    smp_r = '0;
    req_r = '0;
    fails = 0;
    comparisons = 0;
    seed = 50;
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'b1;
    #1;
    chk(pin_level, 1'b0);
    foreach (rst_a[i]) rd(rst_a[i], 8'h00);
    // Both thresholds zero: even inside sense must stay quiet.
    wr(ADDR_SETUP, 8'h08);
    smp(16'h0500);
    rd(ADDR_STATE, 8'h00);
    chk(pin_level, 1'b0);
    // High side disabled: the low side alone must still fire.
    wr(ADDR_SETUP, 8'h00);
    wr(ADDR_LO_H, 8'h08);
    smp(16'h0001);
    chk(pin_level, 1'b1);
    rd(ADDR_STATE, 8'h06);
    wr(ADDR_LO_H, 8'h00);
    // Host programs the setup during init; low side left disabled at first.
    wr(ADDR_HI_H, 8'h10);
    for (int i = 0; i < 5; i++) begin
      if (i == 2) wr(ADDR_LO_H, 8'h08);
      wr(ADDR_SETUP, tb_set[i]);
      smp(tb_val[i]);
      chk(pin_level, tb_st[i][2]);
      rd(ADDR_STATE, tb_st[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rv = 16'h0800 + 16'($random(seed) & 32'h03FF);
      smp(rv);
      chk(pin_level, 1'b1);
    end
    // Active-low drive inverts the asserted level.
    wr(ADDR_PIN_CFG, 8'h04);
    chk({pin_level, pull_up}, 2'b01);
    wr(ADDR_PIN_CFG, 8'h00);
    chk({pin_level, pull_dn}, 2'b11);
    for (int s = 1; s < 4; s++) begin
      wr(ADDR_IRQ_STAT, 8'h03);
      wr(ADDR_SETUP, 8'(s << SEL_LSB));
      smp(16'h2000);
      rd(ADDR_STATE, 8'h07);
      smp(16'h0900);
      rd(ADDR_STATE, 8'h05);
      n = 6;
      while (pin_level === 1'b1 && n < 3000) begin
        @(posedge i_clk);
        #1;
        n++;
      end
      // A pin still held at the bound is a hang: count it and stop the run.
      if (pin_level === 1'b1) begin
        fails++;
        final_report();
      end
      cyc = (16 << (2 * (s - 1))) * 2 * TP;
      chk(n >= cyc && n <= cyc + TP, 1'b1);
      rd(ADDR_STATE, 8'h00);
      rd(ADDR_IRQ_STAT, 8'h03);
      chk(o_irq, 1'b0);
      wr(ADDR_IRQ_MASK, 8'h02);
      chk(o_irq, 1'b1);
      wr(ADDR_IRQ_STAT, 8'h02);
      chk(o_irq, 1'b0);
      wr(ADDR_IRQ_MASK, 8'h00);
    end
    // After the lock, setup and threshold writes are dropped.
    wr(ADDR_LOCK, 8'h01);
    wr(ADDR_SETUP, 8'h08);
    wr(ADDR_HI_L, 8'hFF);
    rd(ADDR_SETUP, 8'h30);
    rd(ADDR_HI_L, 8'h00);
    repeat (3) @(posedge i_clk);
    final_report();
  end
endmodule : pressure_irq_stretch_window_tb

`default_nettype wire
